// *** rss_pkg.sv ***
`default_nettype none
package rss_pkg;
    localparam int CLK_KHZ      = 250_000;
    localparam int T_RST_MS     = 160;
    localparam int PB_DB_MS     = 160;
    localparam int OSC_START_MS = 1000;
    localparam int WD_STEP_MS   = 10;
    localparam int T_RST_CYC    = T_RST_MS * CLK_KHZ;
    localparam int PB_DB_CYC    = PB_DB_MS * CLK_KHZ;
    localparam int OSC_CYC      = OSC_START_MS * CLK_KHZ;
    localparam int WD_STEP_CYC  = WD_STEP_MS * CLK_KHZ;
    localparam int OSC_DIV      = 32768;
    localparam int WD_MAX_UNITS = 9999;
    localparam int REG_COUNT    = 8;
    localparam logic [7:0] TIME_RESET  = 8'h00;
    // Arbitrary bus address
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
    localparam int PIN_W = 5;

    typedef enum logic [1:0] {RS_POWER, RS_HOLD, RS_RUN} rss_rst_state_t;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WR, I_ACK, I_RD, I_RACK} rss_i2c_state_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic rstPin;
        logic powerFail;
        logic oscIn;
    } rss_pins_t;
endpackage : rss_pkg
`default_nettype wire

// *** rss_supervisor.sv ***
// Overview of operation
// (R1) Reset pin pulled low while supply is below power_fail_trip_level.
// (R2) Reset released after supply stays good for the reset hold time.
// (R3) Reset pin is open-drain, active low, never driven high.
// (R4) External low on reset pin is debounced, then starts a reset.
// (R5) Oscillator disabled adds startup time to the reset hold.
// (R6) Watchdog in 10 ms steps, 0.01 to 99.99 s, resets on expiry; wdTimeout is not capped at 9999 units, so up to 163.83 s.
// (R7) Device is bus target only; never drives clock or START/STOP.
// (R8) Controller sends START, address byte, then data bytes.
// (R9) Pointer advances after each byte until STOP.
// (R10) Register access blocked while supply is below trip level.
// (R11) Access accepted only after the reset output has gone high.
// (R12) Registers kept alive on backup_supply during supply loss.
// (R13) First power-up loads time and date registers with zeros.
// (R14) Host should write valid time values after first power-up.
// (R15) Timebase from 32.768 kHz crystal or external oscillator input.
// (R16) Address not acknowledged while access is blocked.
// (R17) Pushbutton level synchronised before debouncing.
`timescale 1ns/1ps
`default_nettype none
module rss_supervisor
    import rss_pkg::*;
#(
    parameter int unsigned HOLD_CYC = T_RST_CYC,
    parameter int unsigned PB_CYC   = PB_DB_CYC,
    parameter int unsigned OSC_SU   = OSC_CYC,
    parameter int unsigned WD_STEP  = WD_STEP_CYC,
    parameter int unsigned OSC_DV   = OSC_DIV,
    parameter logic [6:0]  DEV_ADDR = DEV_ADDR_DEF
) (
    input  wire logic        clk,          // 250 MHz
    input  wire logic        resetn,       // First power-up reset
    input  wire logic        powerFail,    // Comparator: supply below trip
    input  wire logic        rstPinIn,     // Reset pin level
    output logic             rstPinOut,    // Reset pin drive value
    output logic             rstPinOe,     // Reset pin pull-low enable
    input  wire logic        scl,          // Serial clock
    input  wire logic        sdaIn,        // Serial data level
    output logic             sdaOut,       // Serial data drive value
    output logic             sdaOe,        // Serial data pull-low enable
    input  wire logic        oscInput,     // Crystal or external oscillator
    output logic             oscOutput,    // Oscillator feedback
    input  wire logic        oscDisabled,  // Oscillator stopped
    input  wire logic        wdEnable,     // Watchdog enable
    input  wire logic [13:0] wdTimeout,    // Timeout in 10 ms units
    input  wire logic        wdKick,       // Watchdog service pulse
    output logic             accessEnable, // Serial access allowed
    output logic             secondTick    // One pulse per second
);
    localparam int PTR_W = $clog2(REG_COUNT);
    localparam logic [31:0] HOLD_L = 32'(HOLD_CYC);
    localparam logic [31:0] OSC_L  = 32'(OSC_SU);
    localparam logic [31:0] PB_L   = 32'(PB_CYC);
    localparam logic [31:0] WDS_L  = 32'(WD_STEP);
    localparam logic [15:0] DIV_L  = 16'(OSC_DV);

    generate
        if (HOLD_CYC < 1 || PB_CYC < 1 || WD_STEP < 1 || OSC_DV < 2 || OSC_DV > 65535) begin : g_chk
            $error("rss_supervisor: bad timing parameter");
        end
    endgenerate

    // Two-flop synchronisers for the bus, reset, power-fail and oscillator pins
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] syncd;
    wire  [PIN_W-1:0] rawIn = {scl, sdaIn, rstPinIn, powerFail, oscInput};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta[gi]  <= 1'b1;
                    syncd[gi] <= 1'b1;
                end else begin
                    meta[gi]  <= rawIn[gi];
                    syncd[gi] <= meta[gi];
                end
            end
        end
    endgenerate
    rss_pins_t pin;
    assign pin = syncd;

    // Reset sequencer
    rss_rst_state_t rstState;
    logic [31:0]    holdCnt;
    logic [31:0]    pbCnt;
    logic           wdFire;
    wire  [31:0]    holdTarget = oscDisabled ? HOLD_L + OSC_L : HOLD_L; // R5
    wire            pbLow      = !pin.rstPin && !rstPinOe;             // R17
    wire            pbFire     = pbLow && (pbCnt == PB_L - 32'h1);     // R4
    wire            holdDone   = holdCnt >= holdTarget - 32'h1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pbCnt <= 32'h0;
        end else begin
            pbCnt <= pbLow && !pbFire ? pbCnt + 32'h1 : 32'h0; // R4
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstState <= RS_POWER;
            holdCnt  <= 32'h0;
        end else if (pin.powerFail) begin
            rstState <= RS_POWER; // R1
            holdCnt  <= 32'h0;
        end else begin
            unique case (rstState)
                RS_POWER: begin
                    rstState <= RS_HOLD;
                    holdCnt  <= 32'h0;
                end
                RS_HOLD: begin
                    holdCnt  <= holdCnt + 32'h1;
                    if (holdDone)
                        rstState <= RS_RUN; // R2
                end
                RS_RUN: begin
                    holdCnt <= 32'h0;
                    if (pbFire || wdFire)
                        rstState <= RS_HOLD; // R4 R6
                end
            endcase
        end
    end
    assign rstPinOut    = 1'b0;                  // R3
    assign rstPinOe     = rstState != RS_RUN;    // R1
    assign accessEnable = rstState == RS_RUN && !pin.powerFail; // R10 R11

    // Watchdog, counted on the system clock in 10 ms steps
    logic [31:0] wdPre;
    logic [13:0] wdUnits;
    logic        addrAck;
    wire         wdRun  = wdEnable && wdTimeout != 14'h0 && rstState == RS_RUN;
    wire         wdStep = wdPre == WDS_L - 32'h1;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdPre   <= 32'h0;
            wdUnits <= 14'h0;
            wdFire  <= 1'b0;
        end else if (!wdRun || wdKick || addrAck) begin
            wdPre   <= 32'h0;
            wdUnits <= 14'h0;
            wdFire  <= 1'b0;
        end else begin
            wdPre  <= wdStep ? 32'h0 : wdPre + 32'h1;
            wdFire <= wdStep && (wdUnits + 14'h1 == wdTimeout); // R6
            if (wdStep)
                wdUnits <= wdUnits + 14'h1;
        end
    end

    // Timebase from the sampled oscillator pin
    logic        oscPrev;
    logic [15:0] oscDiv;
    wire         oscRise = pin.oscIn && !oscPrev;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oscPrev    <= 1'b1; // Same as the synchroniser reset, so no false edge
            oscDiv     <= 16'h0;
            secondTick <= 1'b0;
            oscOutput  <= 1'b0;
        end else begin
            oscPrev    <= pin.oscIn;
            oscOutput  <= !oscDisabled && !pin.oscIn; // R15
            secondTick <= !oscDisabled && oscRise && oscDiv == DIV_L - 16'h1;
            if (!oscDisabled && oscRise)
                oscDiv <= oscDiv == DIV_L - 16'h1 ? 16'h0 : oscDiv + 16'h1; // R15
        end
    end

    // Serial target
    rss_i2c_state_t i2cState;
    logic [3:0]       bitCnt;
    logic [7:0]       shReg;
    logic [7:0]       txReg;
    logic [PTR_W-1:0] ptr;
    logic             ptrPhase;
    logic             readMode;
    logic             masterAck;
    logic             sclPrev;
    logic             sdaPrev;
    logic             sdaDrive;
    logic [7:0]       timeReg [REG_COUNT];

    wire startCond = pin.scl && sclPrev && sdaPrev && !pin.sda;
    wire stopCond  = pin.scl && sclPrev && !sdaPrev && pin.sda;
    wire sclRise   = pin.scl && !sclPrev;
    wire sclFall   = !pin.scl && sclPrev;
    wire byteDone  = bitCnt == 4'h8;
    wire addrHit   = shReg[7:1] == DEV_ADDR && accessEnable;      // R16
    wire [PTR_W-1:0] ptrNext = ptr == PTR_W'(REG_COUNT - 1) ? '0 : ptr + PTR_W'(1); // R9
    wire [PTR_W-1:0] ptrLoad = shReg < 8'(REG_COUNT) ? shReg[PTR_W-1:0] : '0;
    wire [7:0]       rdData  = timeReg[ptr];
    wire busEvent  = accessEnable && !startCond && !stopCond;
    wire wrEn      = busEvent && sclFall && i2cState == I_WR && byteDone && !ptrPhase;
    wire loadRead  = (i2cState == I_ACK && readMode) || (i2cState == I_RACK && masterAck);
    assign addrAck = busEvent && sclFall && i2cState == I_ADDR && byteDone && addrHit;
    assign sdaOut  = 1'b0; // R7
    assign sdaOe   = sdaDrive;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= pin.scl;
            sdaPrev <= pin.sda;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            i2cState  <= I_IDLE;
            bitCnt    <= 4'h0;
            shReg     <= 8'h0;
            txReg     <= 8'h0;
            ptr       <= '0;
            ptrPhase  <= 1'b1;
            readMode  <= 1'b0;
            masterAck <= 1'b0;
            sdaDrive  <= 1'b0;
        end else if (!accessEnable) begin
            i2cState <= I_IDLE; // R10
            sdaDrive <= 1'b0;
        end else if (startCond) begin
            i2cState <= I_ADDR; // R8
            bitCnt   <= 4'h0;
            ptrPhase <= 1'b1;
            sdaDrive <= 1'b0;
        end else if (stopCond) begin
            i2cState <= I_IDLE; // R9
            sdaDrive <= 1'b0;
        end else if (sclRise) begin
            if (i2cState == I_ADDR || i2cState == I_WR) begin
                shReg  <= {shReg[6:0], pin.sda};
                bitCnt <= bitCnt + 4'h1;
            end
            if (i2cState == I_RACK)
                masterAck <= !pin.sda;
        end else if (sclFall) begin
            if (loadRead) begin
                txReg    <= {rdData[6:0], 1'b0};
                sdaDrive <= !rdData[7];
                ptr      <= ptrNext; // R9
                bitCnt   <= 4'h1;
                i2cState <= I_RD;
            end else begin
                unique case (i2cState)
                    I_IDLE: ;
                    I_ADDR: if (byteDone) begin
                        readMode <= shReg[0];
                        sdaDrive <= addrHit;                  // R16
                        i2cState <= addrHit ? I_ACK : I_IDLE;
                    end
                    I_WR: if (byteDone) begin
                        ptr      <= ptrPhase ? ptrLoad : ptrNext; // R9
                        ptrPhase <= 1'b0;
                        sdaDrive <= 1'b1;
                        i2cState <= I_ACK;
                    end
                    I_ACK: begin
                        sdaDrive <= 1'b0;
                        bitCnt   <= 4'h0;
                        i2cState <= I_WR;
                    end
                    I_RD: begin
                        if (byteDone) begin
                            sdaDrive <= 1'b0;
                            i2cState <= I_RACK;
                        end else begin
                            sdaDrive <= !txReg[7];
                            txReg    <= {txReg[6:0], 1'b0};
                            bitCnt   <= bitCnt + 4'h1;
                        end
                    end
                    I_RACK: begin
                        sdaDrive <= 1'b0;
                        i2cState <= I_IDLE;
                    end
                endcase
            end
        end
    end

    // Only resetn clears the registers: supply loss leaves them intact
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < REG_COUNT; i++)
                timeReg[i] <= TIME_RESET; // R13
        end else if (wrEn) begin
            timeReg[ptr] <= shReg; // R12
        end
    end

    sequence s_holdEnd;
        $fell(rstPinOe);
    endsequence
    sequence s_blocked;
        !accessEnable;
    endsequence

    AST_PF_RESET: assert property (@(posedge clk) disable iff (!resetn) // R1
        pin.powerFail |=> rstPinOe && rstState == RS_POWER)
        else $error("reset not asserted on power fail");
    AST_HOLD_TIME: assert property (@(posedge clk) disable iff (!resetn) // R2
        s_holdEnd |-> $past(holdCnt) == $past(holdTarget) - 32'h1)
        else $error("reset released at wrong hold count");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!resetn) // R3
        rstPinOut == 1'b0 && sdaOut == 1'b0)
        else $error("open-drain pin driven high");
    AST_PB_RESET: assert property (@(posedge clk) disable iff (!resetn) // R4
        pbFire && rstState == RS_RUN && !pin.powerFail |=> rstState == RS_HOLD && holdCnt == 32'h0)
        else $error("debounced press did not start reset");
    AST_OSC_EXT: assert property (@(posedge clk) disable iff (!resetn) // R5
        oscDisabled |-> holdTarget == HOLD_L + OSC_L)
        else $error("oscillator startup not added");
    AST_WD_RESET: assert property (@(posedge clk) disable iff (!resetn) // R6
        wdFire && rstState == RS_RUN && !pin.powerFail |=> rstPinOe [*2])
        else $error("watchdog expiry did not reset");
    AST_BLOCKED: assert property (@(posedge clk) disable iff (!resetn) // R10
        s_blocked |-> !wrEn && !addrAck ##1 i2cState == I_IDLE && !sdaOe)
        else $error("access while blocked");
    AST_ACCESS_AFTER_RST: assert property (@(posedge clk) disable iff (!resetn) // R11
        $fell(rstPinOe) && !pin.powerFail |-> accessEnable && !$past(accessEnable))
        else $error("access enable not tied to reset release");
    AST_PTR_ADV: assert property (@(posedge clk) disable iff (!resetn) // R9
        wrEn |=> ptr == $past(ptrNext) && i2cState == I_ACK)
        else $error("pointer did not advance");
endmodule : rss_supervisor
`default_nettype wire

// *** rss_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_host_model
    import rss_pkg::*;
(
    input  wire logic sda,    // Resolved data wire
    output logic      scl,    // Bus clock, idle high
    output logic      sdaLow  // Pull data low
);
    // Quarter of a 125 ns bit, free of the system clock phase
    localparam realtime Q = 31.25;
    logic [7:0] txBuf [8];
    logic [7:0] rxBuf [8];

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic startBit();
        sdaLow = 1'b0;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : startBit

    task automatic stopBit();
        sdaLow = 1'b1;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b0;
        #Q;
    endtask : stopBit

    // Eight bits out or in, then the acknowledge slot
    task automatic byteIO(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx, output logic ackIn);
        logic [8:0] v;
        v = {tx, ~ackOut};
        for (int i = 8; i >= 0; i--) begin
            sdaLow = ~v[i];
            #Q scl = 1'b1;
            #(2 * Q);
            if (i > 0) rx = {rx[6:0], sda};
            else ackIn = ~sda;
            scl = 1'b0;
            #Q;
        end
        sdaLow = 1'b0;
    endtask : byteIO

    task automatic access(input logic [6:0] addr, input logic rd, input logic [7:0] ptr, input int n,
                          output logic ok);
        logic [7:0] rx;
        logic       a;
        // Sub-nanosecond offset keeps every bus edge off a rising system clock edge
        #0.1;
        startBit();
        byteIO({addr, 1'b0}, 1'b0, rx, ok);
        if (ok) byteIO(ptr, 1'b0, rx, a);
        if (ok && rd) begin
            startBit();
            byteIO({addr, 1'b1}, 1'b0, rx, a);
        end
        for (int i = 0; i < n && ok; i++) begin
            if (rd) byteIO(8'hff, i != n - 1, rxBuf[i], a);
            else byteIO(txBuf[i], 1'b0, rx, a);
        end
        stopBit();
    endtask : access
endmodule : rss_host_model
`default_nettype wire

// *** rss_supervisor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_supervisor_test
    import rss_pkg::*;
;
    localparam int HOLD = 40, PB = 20, OSC = 30, STEP = 10, DV = 4;
    logic        clk, resetn, powerFail, rstPinIn, rstPinOut, rstPinOe, scl, sdaIn, sdaOut, sdaOe;
    logic        oscInput, oscOutput, oscDisabled, wdEnable, wdKick, accessEnable, secondTick;
    logic        pbLow, sdaLow, ok;
    logic [13:0] wdTimeout;
    logic [7:0]  shadow [8];
    int          numErrors = 0, compares = 0, n;

    // Both wires have pull-ups: high unless someone pulls
    assign rstPinIn = ~(rstPinOe | pbLow);
    assign sdaIn = ~(sdaOe | sdaLow);

    rss_supervisor #(.HOLD_CYC(HOLD), .PB_CYC(PB), .OSC_SU(OSC), .WD_STEP(STEP), .OSC_DV(DV)) i_dut (
        .clk(clk), .resetn(resetn), .powerFail(powerFail), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
        .rstPinOe(rstPinOe), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .oscInput(oscInput), .oscOutput(oscOutput), .oscDisabled(oscDisabled), .wdEnable(wdEnable),
        .wdTimeout(wdTimeout), .wdKick(wdKick), .accessEnable(accessEnable), .secondTick(secondTick));
    rss_host_model i_host (.sda(sdaIn), .scl(scl), .sdaLow(sdaLow));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        oscInput = 1'b0;
        #1;
        forever #100 oscInput = ~oscInput;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrapUp();
        $display("Comparisons %0d, mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrapUp

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick

    function automatic logic inRange(int v, int lo, int hi);
        return v >= lo && v <= hi;
    endfunction : inRange

    task automatic waitOe(input logic lvl, input int lim, output int c);
        c = 0;
        while (rstPinOe !== lvl) begin
            tick(1);
            c++;
            if (c > lim) begin
                check("resetWait", c, lim);
                wrapUp();
            end
        end
    endtask : waitOe

    task automatic busRead(input logic [7:0] p, input int k);
        int b;
        b = p < REG_COUNT ? int'(p) : 0;
        i_host.access(DEV_ADDR_DEF, 1'b1, p, k, ok);
        check("readAck", ok, 1);
        for (int i = 0; i < k; i++) check("readData", i_host.rxBuf[i], shadow[(b + i) % REG_COUNT]);
    endtask : busRead

    task automatic busWrite(input logic [7:0] p, input int k);
        for (int i = 0; i < k; i++) begin
            i_host.txBuf[i] = 8'($urandom);
            shadow[(p + i) % REG_COUNT] = i_host.txBuf[i];
        end
        i_host.access(DEV_ADDR_DEF, 1'b0, p, k, ok);
        check("writeAck", ok, 1);
    endtask : busWrite

    task automatic powerCycle(input logic dis);
        oscDisabled = dis;
        powerFail = 1'b1;
        tick(5);
        check("failOe", rstPinOe, 1);
        check("failAccess", accessEnable, 0);
        check("pinDrive", {rstPinOut, sdaOut}, 0);
        if (dis) check("oscStop", oscOutput, 0);
        i_host.access(DEV_ADDR_DEF, 1'b0, 8'h00, 0, ok);
        check("failAck", ok, 0);
        powerFail = 1'b0;
        tick(HOLD / 2);
        check("holdAccess", accessEnable, 0);
        waitOe(1'b0, HOLD + OSC + 20, n);
        check("holdLen", inRange(n + HOLD / 2, HOLD + (dis ? OSC : 0), HOLD + (dis ? OSC : 0) + 7), 1);
        tick(1);
        check("openAccess", accessEnable, 1);
        oscDisabled = 1'b0;
    endtask : powerCycle

    initial begin
        {resetn, powerFail, pbLow, oscDisabled, wdEnable, wdKick} = '0;
        wdTimeout = '0;
        void'($urandom(26028));
        for (int i = 0; i < 8; i++) shadow[i] = TIME_RESET;
        tick(11);
        check("resetOe", rstPinOe, 1);
        check("resetAccess", accessEnable, 0);
        tick(1);
        resetn = 1'b1;
        tick(HOLD - 4);
        check("holdOe", rstPinOe, 1);
        waitOe(1'b0, 20, n);
        $display("Test power-up done");
        busRead(8'h00, 8);
        busWrite(8'h00, 8);
        busWrite(8'(REG_COUNT - 1), 3);
        busRead(8'($urandom_range(7)), 8);
        busRead(8'h0c, 2);
        i_host.access(DEV_ADDR_DEF ^ 7'h01, 1'b0, 8'h00, 0, ok);
        check("otherAddr", ok, 0);
        $display("Test bus done");
        powerCycle(1'b0);
        busRead(8'h00, 8);
        powerCycle(1'b1);
        $display("Test power fail done");
        pbLow = 1'b1;
        tick(PB - 6);
        pbLow = 1'b0;
        tick(10);
        check("shortPress", rstPinOe, 0);
        pbLow = 1'b1;
        tick(PB + 8);
        check("longPress", rstPinOe, 1);
        pbLow = 1'b0;
        waitOe(1'b0, HOLD + 20, n);
        check("pressHold", inRange(n, HOLD - 15, HOLD + 5), 1);
        $display("Test pushbutton done");
        wdEnable = 1'b1;
        tick(60);
        check("wdOff", rstPinOe, 0);
        wdTimeout = 14'($urandom_range(4, 1));
        repeat (4) begin
            tick(wdTimeout * STEP - 6);
            wdKick = 1'b1;
            tick(1);
            wdKick = 1'b0;
        end
        check("kicked", rstPinOe, 0);
        waitOe(1'b1, 60, n);
        check("wdFire", inRange(n, wdTimeout * STEP - 3, wdTimeout * STEP + 3), 1);
        wdEnable = 1'b0;
        waitOe(1'b0, HOLD + 10, n);
        $display("Test watchdog done");
        n = 0;
        repeat (800) begin
            tick(1);
            if (secondTick === 1'b1) n++;
        end
        check("ticks", inRange(n, 3, 5), 1);
        $display("Test timebase done");
        wrapUp();
    end
endmodule : rss_supervisor_test
`default_nettype wire
